// ### rtl/spu_pkg.sv
// Constants for the serial port, update strobe and sync clock logic.
// Assumes a single core clock domain; all pins arrive asynchronously.
package spu_pkg;

  localparam int SYNC_STAGES = 3;
  localparam int REG_W = 32;
  localparam int NUM_REGS = 4;
  localparam logic [1:0] DIV_RISE_PHASE = 2'h2;
  // Phase our counter should hold when the synchronized reference edge is seen
  localparam logic [1:0] AUTO_TARGET_PHASE = 2'h1;

  localparam logic [4:0] ADDR_CTRL_ONE = 5'h00;
  localparam logic [4:0] ADDR_CTRL_TWO = 5'h01;
  localparam logic [4:0] ADDR_AMP_SCALE = 5'h02;
  localparam logic [4:0] ADDR_FREQ_WORD = 5'h04;

  localparam logic [1:0] IDX_CTRL_ONE = 2'h0;
  localparam logic [1:0] IDX_CTRL_TWO = 2'h1;
  localparam logic [1:0] IDX_AMP_SCALE = 2'h2;
  localparam logic [1:0] IDX_FREQ_WORD = 2'h3;

  localparam logic [2:0] BYTES_CTRL_ONE = 3'h4;
  localparam logic [2:0] BYTES_CTRL_TWO = 3'h3;
  localparam logic [2:0] BYTES_AMP_SCALE = 3'h2;
  localparam logic [2:0] BYTES_FREQ_WORD = 3'h4;
  localparam logic [2:0] BYTES_UNMAPPED = 3'h1;

  localparam int INSTR_RW_BIT = 7;
  localparam int BIT_LSB_FIRST = 8;
  localparam int BIT_SDIO_INPUT_ONLY = 9;
  localparam int BIT_SOFT_SYNC = 22;
  localparam int BIT_AUTO_SYNC = 23;
  localparam int BIT_OSC_BUF_EN = 9;
  localparam int BIT_HW_SYNC = 10;
  localparam int BIT_HS_SYNC_ENH = 11;

  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [REG_W-1:0] REG_RESET = 32'h0000_0000;

endpackage

// ### rtl/spu_serial_port.sv
// Serial control port, buffered register bank and update transfer.
// Assumes all pin inputs are asynchronous to core_clk and the serial
// clock is well below the core clock, so it is oversampled.
`timescale 1ns/100ps
`default_nettype none
module spu_serial_port
  import spu_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Serial pins
  input wire logic sclk,
  input wire logic chip_select_low,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  input wire logic port_abort_input,
  // Update and sync pins
  input wire logic io_update,
  input wire logic sync_ref_in,
  output logic sync_clk_out,
  output logic update_pulse,
  // Active register contents
  output logic [REG_W-1:0] control_function_reg_one,
  output logic [REG_W-1:0] control_function_reg_two,
  output logic [REG_W-1:0] amp_scale_reg,
  output logic [REG_W-1:0] freq_word_reg,
  output logic osc_buf_en,
  output logic hs_sync_enh
);

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic [1:0] reg_index(input logic [4:0] a);
    unique case (a)
      ADDR_CTRL_ONE: reg_index = IDX_CTRL_ONE;
      ADDR_CTRL_TWO: reg_index = IDX_CTRL_TWO;
      ADDR_AMP_SCALE: reg_index = IDX_AMP_SCALE;
      ADDR_FREQ_WORD: reg_index = IDX_FREQ_WORD;
      default: reg_index = IDX_CTRL_ONE;
    endcase
  endfunction

  function automatic logic reg_mapped(input logic [4:0] a);
    reg_mapped = (a == ADDR_CTRL_ONE) || (a == ADDR_CTRL_TWO) ||
      (a == ADDR_AMP_SCALE) || (a == ADDR_FREQ_WORD);
  endfunction

  function automatic logic [2:0] reg_bytes(input logic [4:0] a);
    unique case (a)
      ADDR_CTRL_ONE: reg_bytes = BYTES_CTRL_ONE;
      ADDR_CTRL_TWO: reg_bytes = BYTES_CTRL_TWO;
      ADDR_AMP_SCALE: reg_bytes = BYTES_AMP_SCALE;
      ADDR_FREQ_WORD: reg_bytes = BYTES_FREQ_WORD;
      default: reg_bytes = BYTES_UNMAPPED;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronizers: a change counts once stages two and three agree

  localparam int NPINS = 5;
  localparam int P_SCLK = 0;
  localparam int P_CSN = 1;
  localparam int P_SDI = 2;
  localparam int P_ABORT = 3;
  localparam int P_REF = 4;

  wire logic [NPINS-1:0] pin_raw;
  logic [NPINS-1:0] pin_s1_reg;
  logic [NPINS-1:0] pin_s2_reg;
  logic [NPINS-1:0] pin_s3_reg;
  logic [NPINS-1:0] pin_lvl_reg;
  logic [NPINS-1:0] pin_prev_reg;

  assign pin_raw = {sync_ref_in, port_abort_input, sdio_in, chip_select_low, sclk};

  genvar g;
  generate
    for (g = 0; g < NPINS; g++)
    begin : g_pin
      always_ff @(posedge core_clk)
      begin
        if (!nrst)
        begin
          pin_s1_reg[g] <= 1'b0;
          pin_s2_reg[g] <= 1'b0;
          pin_s3_reg[g] <= 1'b0;
          pin_lvl_reg[g] <= (g == P_CSN);
          pin_prev_reg[g] <= (g == P_CSN);
        end
        else
        begin
          pin_s1_reg[g] <= pin_raw[g];
          pin_s2_reg[g] <= pin_s1_reg[g];
          pin_s3_reg[g] <= pin_s2_reg[g];
          if (pin_s2_reg[g] == pin_s3_reg[g])
            pin_lvl_reg[g] <= pin_s3_reg[g];
          pin_prev_reg[g] <= pin_lvl_reg[g];
        end
      end
    end
  endgenerate

  wire logic sclk_rise;
  wire logic sclk_fall;
  wire logic csn_lvl;
  wire logic sdi_lvl;
  wire logic abort_lvl;
  wire logic ref_rise;

  assign csn_lvl = pin_lvl_reg[P_CSN];
  assign sdi_lvl = pin_lvl_reg[P_SDI];
  assign abort_lvl = pin_lvl_reg[P_ABORT];
  // Edges are ignored while deselected, so the cycle simply pauses
  assign sclk_rise = pin_lvl_reg[P_SCLK] && !pin_prev_reg[P_SCLK] && !csn_lvl && !abort_lvl;
  assign sclk_fall = !pin_lvl_reg[P_SCLK] && pin_prev_reg[P_SCLK] && !csn_lvl && !abort_lvl;
  assign ref_rise = pin_lvl_reg[P_REF] && !pin_prev_reg[P_REF];

  ////////////////////////////////////////////////////////////////////////
  // Serial state

  typedef enum logic {SPU_INSTR, SPU_DATA} spu_phase_e;

  spu_phase_e phase_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] byte_cnt_reg;
  logic [2:0] nbytes_reg;
  logic [7:0] shift_reg;
  logic rd_reg;
  logic [4:0] addr_reg;
  logic [REG_W-1:0] buf_mem [0:NUM_REGS-1];
  logic [REG_W-1:0] act_reg [0:NUM_REGS-1];

  wire logic lsb_first;
  wire logic sdio_input_only;
  wire logic [7:0] shift_next;
  wire logic byte_done;
  wire logic last_byte;
  wire logic [1:0] cur_idx;
  wire logic [1:0] lane;
  wire logic [7:0] tx_byte;
  wire logic [2:0] tx_bit;
  wire logic wr_byte;

  assign lsb_first = act_reg[IDX_CTRL_ONE][BIT_LSB_FIRST];
  assign sdio_input_only = act_reg[IDX_CTRL_ONE][BIT_SDIO_INPUT_ONLY];
  assign shift_next = lsb_first ? {sdi_lvl, shift_reg[7:1]} : {shift_reg[6:0], sdi_lvl};
  assign byte_done = sclk_rise && (bit_cnt_reg == LAST_BIT);
  assign last_byte = (byte_cnt_reg == nbytes_reg - 3'h1);
  assign cur_idx = reg_index(addr_reg);
  // Register byte address is generated internally from byte count and order
  assign lane = lsb_first ? byte_cnt_reg[1:0] : 2'(nbytes_reg - 3'h1 - byte_cnt_reg);
  assign tx_byte = buf_mem[cur_idx][8*lane +: 8];
  assign tx_bit = lsb_first ? bit_cnt_reg : 3'(LAST_BIT - bit_cnt_reg);
  assign wr_byte = byte_done && (phase_reg == SPU_DATA) && !rd_reg && reg_mapped(addr_reg);

  always_ff @(posedge core_clk)
  begin
    if (!nrst || abort_lvl)
    begin
      phase_reg <= SPU_INSTR;
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 3'h0;
      nbytes_reg <= BYTES_UNMAPPED;
      shift_reg <= 8'h00;
      rd_reg <= 1'b0;
      addr_reg <= 5'h00;
    end
    else if (sclk_rise)
    begin
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (byte_done && phase_reg == SPU_INSTR)
      begin
        rd_reg <= shift_next[INSTR_RW_BIT];
        addr_reg <= shift_next[4:0];
        nbytes_reg <= reg_bytes(shift_next[4:0]);
        byte_cnt_reg <= 3'h0;
        phase_reg <= SPU_DATA;
      end
      else if (byte_done)
      begin
        byte_cnt_reg <= byte_cnt_reg + 3'h1;
        if (last_byte)
          phase_reg <= SPU_INSTR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output drive: launched on falling serial clock edges

  wire logic driving;

  assign driving = !csn_lvl && !abort_lvl && rd_reg && (phase_reg == SPU_DATA);

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      sdio_out <= 1'b0;
      serial_data_out <= 1'b0;
      sdio_oe <= 1'b0;
      serial_data_out_oe <= 1'b0;
    end
    else
    begin
      if (sclk_fall && driving)
      begin
        sdio_out <= tx_byte[tx_bit];
        serial_data_out <= tx_byte[tx_bit];
      end
      sdio_oe <= driving && !sdio_input_only;
      serial_data_out_oe <= driving && sdio_input_only;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Divided clock and update strobe

  logic [SYNC_STAGES-1:0] upd_sync_reg;
  logic upd_lvl_reg;
  logic upd_smp_reg;
  logic upd_smp_prev_reg;
  logic soft_adv_reg;
  wire logic div_clk;
  wire logic div_rise;
  wire logic do_update;

  spu_sync_div u_div (
    .core_clk(core_clk),
    .nrst(nrst),
    .soft_adv(soft_adv_reg),
    .ref_rise(ref_rise),
    .auto_en(act_reg[IDX_CTRL_ONE][BIT_AUTO_SYNC]),
    .hw_man_en(act_reg[IDX_CTRL_TWO][BIT_HW_SYNC]),
    .div_clk_reg(div_clk),
    .div_rise_reg(div_rise)
  );

  assign do_update = upd_smp_reg && !upd_smp_prev_reg;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      upd_sync_reg <= '0;
      upd_lvl_reg <= 1'b0;
      upd_smp_reg <= 1'b0;
      upd_smp_prev_reg <= 1'b0;
      soft_adv_reg <= 1'b0;
      update_pulse <= 1'b0;
    end
    else
    begin
      upd_sync_reg <= {upd_sync_reg[SYNC_STAGES-2:0], io_update};
      if (upd_sync_reg[SYNC_STAGES-1] == upd_sync_reg[SYNC_STAGES-2])
        upd_lvl_reg <= upd_sync_reg[SYNC_STAGES-1];
      if (div_rise)
      begin
        upd_smp_reg <= upd_lvl_reg;
        upd_smp_prev_reg <= upd_smp_reg;
      end
      update_pulse <= do_update && div_rise;
      soft_adv_reg <= do_update && div_rise && buf_mem[IDX_CTRL_ONE][BIT_SOFT_SYNC];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Buffer and active register bank

  generate
    for (g = 0; g < NUM_REGS; g++)
    begin : g_reg
      wire logic hit;
      wire logic xfer;
      assign hit = wr_byte && (cur_idx == 2'(g));
      assign xfer = do_update && div_rise;
      always_ff @(posedge core_clk)
      begin
        if (!nrst)
        begin
          buf_mem[g] <= REG_RESET;
          act_reg[g] <= REG_RESET;
        end
        else
        begin
          // Clear first so that a write of the same byte in this cycle wins
          if (xfer && g == IDX_CTRL_ONE)
            buf_mem[g][BIT_SOFT_SYNC] <= 1'b0;
          if (hit)
            buf_mem[g][8*lane +: 8] <= shift_next;
          if (xfer)
          begin
            act_reg[g] <= buf_mem[g];
            if (g == IDX_CTRL_ONE)
              act_reg[g][BIT_SOFT_SYNC] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      sync_clk_out <= 1'b0;
      control_function_reg_one <= REG_RESET;
      control_function_reg_two <= REG_RESET;
      amp_scale_reg <= REG_RESET;
      freq_word_reg <= REG_RESET;
      osc_buf_en <= 1'b0;
      hs_sync_enh <= 1'b0;
    end
    else
    begin
      sync_clk_out <= div_clk;
      control_function_reg_one <= act_reg[IDX_CTRL_ONE];
      control_function_reg_two <= act_reg[IDX_CTRL_TWO];
      amp_scale_reg <= act_reg[IDX_AMP_SCALE];
      freq_word_reg <= act_reg[IDX_FREQ_WORD];
      osc_buf_en <= act_reg[IDX_CTRL_TWO][BIT_OSC_BUF_EN];
      hs_sync_enh <= act_reg[IDX_CTRL_TWO][BIT_HS_SYNC_ENH];
    end
  end

endmodule
`default_nettype wire

// ### rtl/spu_sync_div.sv
// Divide-by-four sync clock generator with phase advance.
// Assumes the reference edge input is already synchronized to core_clk.
`timescale 1ns/100ps
`default_nettype none
module spu_sync_div
  import spu_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Phase control
  input wire logic soft_adv,
  input wire logic ref_rise,
  input wire logic auto_en,
  input wire logic hw_man_en,
  // Divided clock
  output logic div_clk_reg,
  output logic div_rise_reg
);

  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  wire logic auto_adv;
  wire logic hw_adv;
  wire logic adv;

  assign auto_adv = auto_en && ref_rise && (cnt_reg != AUTO_TARGET_PHASE);
  assign hw_adv = hw_man_en && ref_rise;
  // One extra count skips one core cycle: a quarter period advance
  assign adv = soft_adv || auto_adv || hw_adv;
  assign cnt_next = cnt_reg + (adv ? 2'h2 : 2'h1);

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      cnt_reg <= 2'h0;
      div_clk_reg <= 1'b0;
      div_rise_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      div_clk_reg <= cnt_next[1];
      div_rise_reg <= !cnt_reg[1] && cnt_next[1];
    end
  end

endmodule
`default_nettype wire

// ### testbench/spu_host_model.sv
// Host controller model: serial pins, update strobe, abort and sync reference.
// Shifts the top bit of its argument first; the bench reverses words for
// LSB-first mode. Assumes a 250 MHz core clock for its timing.
`timescale 1ns/100ps
`default_nettype none
module spu_host_model
(
  // Clock
  input wire logic core_clk,
  // Serial pins
  output var logic sclk,
  output var logic chip_select_low,
  output logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  // Control pins
  output var logic port_abort_input,
  output var logic io_update,
  output var logic sync_ref_in
);
  logic drv_en;
  logic drv_bit;
  // A released line shows the inverse of the last bit, never a stale copy
  assign sdio_in = sdio_oe ? sdio_out : (drv_en ? drv_bit : ~drv_bit);
  initial
  begin
    {sclk, drv_en, drv_bit, port_abort_input, io_update, sync_ref_in} = 6'h00;
    chip_select_low = 1'b1;
  end
  // Serial clock low 8 and high 7 core cycles, about 17 MHz
  task automatic shift(input logic [39:0] d, input int n, input logic rd,
    output logic [39:0] q);
    q = 40'h0;
    for (int i = n - 1; i >= 0; i--)
    begin
      @(negedge core_clk);
      sclk = 1'b0;
      drv_en = !rd;
      drv_bit = d[i];
      repeat (8) @(negedge core_clk);
      q[i] = serial_data_out_oe ? serial_data_out : sdio_in;
      sclk = 1'b1;
      repeat (6) @(negedge core_clk);
    end
    drv_en = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] ins, input logic [31:0] wd, input int nb,
    output logic [31:0] rd);
    logic [39:0] q;
    shift({32'h0, ins}, 8, 1'b0, q);
    shift({8'h0, wd}, nb * 8, ins[7], q);
    rd = q[31:0];
  endtask
  task automatic sel(input logic v);
    @(negedge core_clk);
    chip_select_low = v;
    repeat (8) @(negedge core_clk);
  endtask
  // Pin 0 strobe, 1 abort, 2 sync reference: high two divided cycles, low four
  task automatic pulse(input int pin);
    @(negedge core_clk);
    io_update = (pin == 0);
    port_abort_input = (pin == 1);
    sync_ref_in = (pin == 2);
    repeat (8) @(negedge core_clk);
    {io_update, port_abort_input, sync_ref_in} = 3'h0;
    repeat (16) @(negedge core_clk);
  endtask
  // Sync reference as a period-4 clock; a late edge of 3 cycles means 1 cycle early
  task automatic ref_run(input int n, input logic late);
    for (int i = 0; i < n; i++)
    begin
      @(negedge core_clk);
      sync_ref_in = 1'b1;
      repeat (2) @(negedge core_clk);
      sync_ref_in = 1'b0;
      repeat ((late && i == 0) ? 4 : 1) @(negedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

// ### testbench/spu_serial_port_assertions.sv
// Concurrent checks on the serial port top ports.
// Assumes one core clock domain with a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module spu_serial_port_assertions
  import spu_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Pins
  input wire logic chip_select_low,
  input wire logic sdio_oe,
  input wire logic serial_data_out_oe,
  input wire logic io_update,
  input wire logic port_abort_input,
  input wire logic sync_clk_out,
  input wire logic update_pulse,
  // Active contents
  input wire logic [REG_W-1:0] control_function_reg_one,
  input wire logic [REG_W-1:0] control_function_reg_two,
  input wire logic [REG_W-1:0] freq_word_reg,
  input wire logic osc_buf_en
);
  logic [3:0] cs_hi_reg;
  logic [3:0] cs_hi_next;
  logic [3:0] age_reg;
  logic [3:0] age_next;
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // Saturating cycle counts since deselect and since the strobe was high
  assign cs_hi_next = !chip_select_low ? 4'h0 : cs_hi_reg + {3'h0, cs_hi_reg != 4'hf};
  assign age_next = io_update ? 4'h0 : age_reg + {3'h0, age_reg != 4'hf};
  always_ff @(posedge core_clk)
  begin
    cs_hi_reg <= nrst ? cs_hi_next : 4'h0;
    age_reg <= nrst ? age_next : 4'hf;
  end
  //////////////////////////////////////////////////////////////////////////////
  chk_div_period:
  assert property ($rose(sync_clk_out) |=> (!$rose(sync_clk_out)) [*2] ##[1:2] $rose(sync_clk_out))
    else $error("sync clock rise spacing wrong");
  chk_upd_cause:
  assert property (update_pulse |-> age_reg <= 4'hc)
    else $error("update pulse without recent strobe");
  chk_upd_single:
  assert property (update_pulse |=> (!update_pulse) [*3])
    else $error("update pulse not single");
  chk_cs_float:
  assert property (cs_hi_reg >= 4'h8 |-> !sdio_oe && !serial_data_out_oe)
    else $error("data pin driven while deselected");
  chk_pins_excl:
  assert property (!(sdio_oe && serial_data_out_oe))
    else $error("both data pins driven");
  chk_sdo_bidir:
  assert property (!control_function_reg_one[9] && !$past(control_function_reg_one[9])
    |-> !serial_data_out_oe)
    else $error("output pin driven in bidirectional mode");
  chk_regs_hold:
  assert property ($changed(freq_word_reg) || $changed(control_function_reg_two)
    |-> $past(update_pulse))
    else $error("active register changed without update");
  chk_osc_follow:
  assert property (osc_buf_en == control_function_reg_two[BIT_OSC_BUF_EN])
    else $error("oscillator enable differs from its bit");
  chk_soft_clear:
  assert property (!control_function_reg_one[BIT_SOFT_SYNC])
    else $error("soft sync bit visible in active copy");
  cov_update: cover property (update_pulse);
  cov_read: cover property (sdio_oe);
  cov_abort: cover property ($rose(port_abort_input) && !chip_select_low);
endmodule
bind spu_serial_port spu_serial_port_assertions u_chk (.core_clk(core_clk), .nrst(nrst),
  .chip_select_low(chip_select_low), .sdio_oe(sdio_oe),
  .serial_data_out_oe(serial_data_out_oe), .io_update(io_update),
  .port_abort_input(port_abort_input), .sync_clk_out(sync_clk_out),
  .update_pulse(update_pulse), .control_function_reg_one(control_function_reg_one),
  .control_function_reg_two(control_function_reg_two), .freq_word_reg(freq_word_reg),
  .osc_buf_en(osc_buf_en));
`default_nettype wire

// ### testbench/spu_serial_port_tb.sv
// Self-checking bench for the serial port, update strobe and sync divider.
// Assumes the host model drives every serial and control pin; the bench drives clock and reset.
`timescale 1ns/100ps
`default_nettype none
module spu_serial_port_tb
  import spu_pkg::*;
;
  logic core_clk, nrst, sclk, chip_select_low, sdio_in, sdio_out, sdio_oe;
  logic serial_data_out, serial_data_out_oe, port_abort_input, io_update;
  logic sync_ref_in, sync_clk_out, update_pulse, osc_buf_en, hs_sync_enh, prev_sc;
  logic [REG_W-1:0] reg_one, reg_two, amp, freq;
  logic [39:0] q;
  logic [31:0] rd;
  int error_cnt = 0, samples_checked = 0, gap = 0, rises = 0, short_gaps = 0;
  int pulses = 0, s0;
  spu_serial_port uut (.core_clk(core_clk), .nrst(nrst), .sclk(sclk),
    .chip_select_low(chip_select_low), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe), .port_abort_input(port_abort_input),
    .io_update(io_update), .sync_ref_in(sync_ref_in), .sync_clk_out(sync_clk_out),
    .update_pulse(update_pulse), .control_function_reg_one(reg_one),
    .control_function_reg_two(reg_two), .amp_scale_reg(amp), .freq_word_reg(freq),
    .osc_buf_en(osc_buf_en), .hs_sync_enh(hs_sync_enh));
  spu_host_model host (.core_clk(core_clk), .sclk(sclk), .chip_select_low(chip_select_low),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
    .port_abort_input(port_abort_input), .io_update(io_update), .sync_ref_in(sync_ref_in));
  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;
  // Count update pulses, divided clock rises and rises that came one cycle early
  always @(posedge core_clk)
  begin
    if (update_pulse === 1'b1)
      pulses++;
    if (sync_clk_out === 1'b1 && prev_sc === 1'b0)
    begin
      rises++;
      if (gap == 3)
        short_gaps++;
      gap = 0;
    end
    gap++;
    prev_sc = sync_clk_out;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bit reversal of the low n bits, for LSB-first words
  function automatic logic [31:0] rev(input logic [31:0] v, input int n);
    rev = 32'h0;
    for (int i = 0; i < n; i++)
      rev[i] = v[n - 1 - i];
  endfunction
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_wr;
    s0 = rises;
    repeat (40) @(negedge core_clk);
    chk(32'(rises - s0), 32'h0000000a);
    chk({30'h0, sdio_oe, serial_data_out_oe}, 32'h0);
    s0 = pulses;
    host.sel(1'b0);
    host.xfer(8'h01, 32'h0000_0200, 3, rd);
    host.sel(1'b1);
    chk({31'h0, osc_buf_en}, 32'h0);
    host.pulse(0);
    chk(reg_two, 32'h0000_0200);
    chk({31'h0, osc_buf_en}, 32'h1);
    chk(32'(pulses - s0), 32'h1);
    $display("divider and write test done");
  endtask
  task automatic t_b2b;
    host.sel(1'b0);
    host.xfer(8'h04, 32'h1234_5678, 4, rd);
    host.xfer(8'h02, 32'h0000_abcd, 2, rd);
    host.xfer(8'he4, 32'h0, 4, rd);
    host.sel(1'b1);
    chk(rd, 32'h1234_5678);
    chk(freq, 32'h0);
    host.pulse(0);
    chk(freq, 32'h1234_5678);
    chk(amp, 32'h0000_abcd);
    $display("back to back test done");
  endtask
  task automatic t_pause_abort;
    host.sel(1'b0);
    host.shift(40'h01aa, 16, 1'b0, q);
    host.sel(1'b1);
    host.shift(40'hff, 8, 1'b0, q);
    host.sel(1'b0);
    host.shift(40'h1166, 16, 1'b0, q);
    host.shift(40'h04d, 12, 1'b0, q);
    host.pulse(1);
    host.xfer(8'h02, 32'h0000_1234, 2, rd);
    host.sel(1'b1);
    host.pulse(0);
    chk(reg_two, 32'h00aa_1166);
    chk(amp, 32'h0000_1234);
    chk(freq, 32'h1234_5678);
    $display("pause and abort test done");
  endtask
  task automatic t_sync;
    s0 = short_gaps;
    host.sel(1'b0);
    host.xfer(8'h00, 32'h0040_0000, 4, rd);
    host.sel(1'b1);
    host.pulse(0);
    host.pulse(0);
    chk(32'(short_gaps - s0), 32'h1);
    chk(reg_one, 32'h0);
    host.sel(1'b0);
    host.xfer(8'h01, 32'h0000_0c00, 3, rd);
    host.sel(1'b1);
    host.pulse(0);
    chk({31'h0, hs_sync_enh}, 32'h1);
    s0 = short_gaps;
    host.pulse(2);
    host.pulse(2);
    chk(32'(short_gaps - s0), 32'h2);
    host.sel(1'b0);
    host.xfer(8'h01, 32'h0, 3, rd);
    host.sel(1'b1);
    host.pulse(0);
    s0 = short_gaps;
    host.pulse(2);
    chk(32'(short_gaps - s0), 32'h0);
    chk({31'h0, hs_sync_enh}, 32'h0);
    $display("sync test done");
  endtask
  task automatic t_auto;
    host.sel(1'b0);
    host.xfer(8'h00, 32'h0080_0000, 4, rd);
    host.sel(1'b1);
    host.pulse(0);
    chk(reg_one, 32'h0080_0000);
    host.ref_run(8, 1'b0);
    s0 = short_gaps;
    host.ref_run(8, 1'b0);
    chk(32'(short_gaps - s0), 32'h0);
    s0 = short_gaps;
    host.ref_run(8, 1'b1);
    chk(32'(short_gaps - s0), 32'h1);
    $display("auto sync test done");
  endtask
  task automatic t_modes;
    host.sel(1'b0);
    host.xfer(8'h00, 32'h0000_0300, 4, rd);
    host.sel(1'b1);
    host.pulse(0);
    chk(reg_one, 32'h0000_0300);
    host.sel(1'b0);
    host.xfer(8'(rev(32'h02, 8)), rev(32'h5a3c, 16), 2, rd);
    host.xfer(8'(rev(32'h82, 8)), 32'h0, 2, rd);
    host.sel(1'b1);
    chk(rev(rd, 16), 32'h0000_5a3c);
    host.pulse(0);
    chk(amp, 32'h0000_5a3c);
    host.sel(1'b0);
    host.xfer(8'h00, 32'h0, 4, rd);
    host.sel(1'b1);
    host.pulse(0);
    chk(reg_one, 32'h0);
    $display("bit order and pin mode test done");
  endtask
  initial
  begin
    nrst = 1'b0;
    repeat (20) @(negedge core_clk);
    nrst = 1'b1;
    repeat (8) @(negedge core_clk);
    t_wr;
    t_b2b;
    t_pause_abort;
    t_sync;
    t_auto;
    t_modes;
    end_sim;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    end_sim;
  end
endmodule
`default_nettype wire
